// ==== design/cts_pkg.sv ====
// Constants and carrier types for the cipher test sequencer
package cts_pkg;
    localparam logic [15:0] OFF_PLAIN_ADDR   = 16'h0000;
    localparam logic [15:0] OFF_CIPHER_ADDR  = 16'h0004;
    localparam logic [15:0] OFF_ENC_COUNT    = 16'h0008;
    localparam logic [15:0] OFF_DEC_COUNT    = 16'h000C;
    localparam logic [15:0] OFF_ENC_KEY0     = 16'h0020;
    localparam logic [15:0] OFF_DEC_KEY0     = 16'h0040;
    localparam logic [4:0]  REG_AREA         = 5'h00;
    localparam int          KEY_BUSY_BIT     = 8;
    localparam int          IN_BUSY_BIT      = 7;
    localparam int          CNT_W            = 7;
    localparam int          ADDR_W           = 7;
    localparam int          CLK_MHZ          = 25;
    localparam int          KEY_SET_NS       = 400;
    localparam int          KEY_SET_CYC      = (KEY_SET_NS * CLK_MHZ) / 1000;
    localparam logic [31:0] RESET_WORD       = 32'h0000_0000;

    // Register write request
    typedef struct packed {
        logic        wr_en;
        logic [15:0] addr;
        logic [31:0] data;
    } cts_wr_t;

    // Buffer RAM write port
    typedef struct packed {
        logic         en;
        logic [6:0]   addr;
        logic [127:0] data;
    } cts_ram_wr_t;
endpackage

// ==== design/cts_top.sv ====
// Cipher test sequencer: register file and run control
`timescale 1ns/100ps
`default_nettype none
module cts_top (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_ce,
    input  wire cts_pkg::cts_wr_t     i_wr,
    input  wire logic                 i_rd_req,
    input  wire logic [15:0]          i_rd_addr,
    output logic                      o_rd_valid,
    output logic [31:0]               o_rd_data,
    output logic [127:0]              o_enc_key_value,
    output logic                      o_enc_key_load_strobe,
    output logic [127:0]              o_dec_key_value,
    output logic                      o_dec_key_load_strobe,
    output logic                      o_enc_block_in_valid,
    input  wire logic                 i_enc_block_in_done,
    input  wire logic                 i_enc_result_valid,
    input  wire logic [127:0]         i_enc_result_word,
    output logic                      o_dec_block_in_valid,
    input  wire logic                 i_dec_block_in_done,
    input  wire logic                 i_dec_result_valid,
    input  wire logic [127:0]         i_dec_result_word,
    output logic [6:0]                o_plain_ram_addr,
    output logic [6:0]                o_cipher_ram_addr,
    output cts_pkg::cts_ram_wr_t      o_plain_wr,
    output cts_pkg::cts_ram_wr_t      o_cipher_wr
);
    localparam int KC = cts_pkg::KEY_SET_CYC;

    // Area check shared by write and read decode
    function automatic logic in_reg_area(input logic [15:0] addr);
        return addr[15:11] == cts_pkg::REG_AREA;
    endfunction

    // Key blocks span four words; match on the upper index bits
    function automatic logic key_hit(input logic [8:0] idx,
                                     input logic [8:0] base);
        return idx[8:2] == base[8:2];
    endfunction

    // Address decode, register area only
    wire        area_hit = in_reg_area(i_wr.addr);
    wire        wr       = i_ce && i_wr.wr_en && area_hit;
    wire [8:0]  widx     = i_wr.addr[10:2];
    wire        wr_pa    = wr && widx == cts_pkg::OFF_PLAIN_ADDR[10:2];
    wire        wr_ca    = wr && widx == cts_pkg::OFF_CIPHER_ADDR[10:2];
    wire        wr_ec    = wr && widx == cts_pkg::OFF_ENC_COUNT[10:2];
    wire        wr_dc    = wr && widx == cts_pkg::OFF_DEC_COUNT[10:2];
    wire [8:0]  ek0      = cts_pkg::OFF_ENC_KEY0[10:2];
    wire [8:0]  dk0      = cts_pkg::OFF_DEC_KEY0[10:2];
    wire        wr_ek    = wr && key_hit(widx, ek0);
    wire        wr_dk    = wr && key_hit(widx, dk0);
    wire [6:0]  wcnt     = i_wr.data[6:0];

    // Key busy counters, key and input busy flags, blocks-left counts
    logic [3:0] enc_key_cnt;
    logic [3:0] dec_key_cnt;
    logic       enc_key_busy_flag;
    logic       dec_key_busy_flag;
    logic       enc_input_busy_flag;
    logic       dec_input_busy_flag;
    logic [6:0] enc_blocks_left;
    logic [6:0] dec_blocks_left;

    // Feed decisions; zero count starts nothing and never wraps
    wire enc_start = wr_ec && wcnt != 7'h00;
    wire dec_start = wr_dc && wcnt != 7'h00;
    wire enc_more  = i_ce && i_enc_block_in_done &&
                     enc_blocks_left != 7'h00;
    wire dec_more  = i_ce && i_dec_block_in_done &&
                     dec_blocks_left != 7'h00;
    wire enc_feed  = enc_start || enc_more;
    wire dec_feed  = dec_start || dec_more;

    // Key registers and load strobes
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_enc_key_value       <= {4{cts_pkg::RESET_WORD}};
            o_dec_key_value       <= {4{cts_pkg::RESET_WORD}};
            o_enc_key_load_strobe <= 1'b0;
            o_dec_key_load_strobe <= 1'b0;
        end else if (i_ce) begin
            o_enc_key_load_strobe <= wr_ek && widx[1:0] == 2'h0;
            o_dec_key_load_strobe <= wr_dk && widx[1:0] == 2'h0;
            if (wr_ek)
                o_enc_key_value[widx[1:0]*32 +: 32] <= i_wr.data;
            if (wr_dk)
                o_dec_key_value[widx[1:0]*32 +: 32] <= i_wr.data;
        end
    end

    // Key setting timers, ten cycles from strobe
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            enc_key_cnt <= 4'h0;
            dec_key_cnt <= 4'h0;
        end else if (i_ce) begin
            if (o_enc_key_load_strobe)
                enc_key_cnt <= 4'(KC - 1);
            else if (enc_key_cnt != 4'h0)
                enc_key_cnt <= enc_key_cnt - 4'h1;
            if (o_dec_key_load_strobe)
                dec_key_cnt <= 4'(KC - 1);
            else if (dec_key_cnt != 4'h0)
                dec_key_cnt <= dec_key_cnt - 4'h1;
        end
    end
    assign enc_key_busy_flag = o_enc_key_load_strobe || enc_key_cnt != 4'h0;
    assign dec_key_busy_flag = o_dec_key_load_strobe || dec_key_cnt != 4'h0;

    // Check helper: busy cycles counted apart from the timers, so the
    // length checks below do not just restate the timer logic
    logic [3:0] enc_busy_len;
    logic [3:0] dec_busy_len;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            enc_busy_len <= 4'h0;
            dec_busy_len <= 4'h0;
        end else if (i_ce) begin
            if (o_enc_key_load_strobe)
                enc_busy_len <= 4'h1;
            else if (enc_key_busy_flag)
                enc_busy_len <= enc_busy_len + 4'h1;
            else
                enc_busy_len <= 4'h0;
            if (o_dec_key_load_strobe)
                dec_busy_len <= 4'h1;
            else if (dec_key_busy_flag)
                dec_busy_len <= dec_busy_len + 4'h1;
            else
                dec_busy_len <= 4'h0;
        end
    end

    // Encrypt run control
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            enc_blocks_left      <= 7'h00;
            o_enc_block_in_valid <= 1'b0;
            enc_input_busy_flag  <= 1'b0;
        end else if (i_ce) begin
            o_enc_block_in_valid <= enc_feed;
            if (enc_start)
                enc_blocks_left <= wcnt - 7'h1;
            else if (enc_more)
                enc_blocks_left <= enc_blocks_left - 7'h1;
            if (enc_feed)
                enc_input_busy_flag <= 1'b1;
            else if (i_enc_block_in_done)
                enc_input_busy_flag <= 1'b0;
        end
    end

    // Decrypt run control
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dec_blocks_left      <= 7'h00;
            o_dec_block_in_valid <= 1'b0;
            dec_input_busy_flag  <= 1'b0;
        end else if (i_ce) begin
            o_dec_block_in_valid <= dec_feed;
            if (dec_start)
                dec_blocks_left <= wcnt - 7'h1;
            else if (dec_more)
                dec_blocks_left <= dec_blocks_left - 7'h1;
            if (dec_feed)
                dec_input_busy_flag <= 1'b1;
            else if (i_dec_block_in_done)
                dec_input_busy_flag <= 1'b0;
        end
    end

    // Buffer addresses: software load, feed step, result step.
    // A feed and a result in one cycle on the same RAM step it only once;
    // software must not run both directions at once.
    wire enc_res = i_ce && i_enc_result_valid;
    wire dec_res = i_ce && i_dec_result_valid;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_plain_ram_addr  <= 7'h00;
            o_cipher_ram_addr <= 7'h00;
            o_plain_wr        <= '0;
            o_cipher_wr       <= '0;
        end else if (i_ce) begin
            o_cipher_wr <= '{en: enc_res, addr: o_cipher_ram_addr,
                             data: i_enc_result_word};
            o_plain_wr  <= '{en: dec_res, addr: o_plain_ram_addr,
                             data: i_dec_result_word};
            if (wr_pa)
                o_plain_ram_addr <= i_wr.data[6:0];
            else if (enc_feed || dec_res)
                o_plain_ram_addr <= o_plain_ram_addr + 7'h1;
            if (wr_ca)
                o_cipher_ram_addr <= i_wr.data[6:0];
            else if (dec_feed || enc_res)
                o_cipher_ram_addr <= o_cipher_ram_addr + 7'h1;
        end
    end

    // Read mux, request then data two cycles later
    wire        rd_area = in_reg_area(i_rd_addr);
    wire [8:0]  ridx    = i_rd_addr[10:2];
    wire [31:0] enc_st  = {23'h0, enc_key_busy_flag, enc_input_busy_flag,
                           enc_blocks_left};
    wire [31:0] dec_st  = {23'h0, dec_key_busy_flag, dec_input_busy_flag,
                           dec_blocks_left};
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (rd_area) begin
            if (ridx == cts_pkg::OFF_PLAIN_ADDR[10:2])
                rd_mux = {25'h0, o_plain_ram_addr};
            else if (ridx == cts_pkg::OFF_CIPHER_ADDR[10:2])
                rd_mux = {25'h0, o_cipher_ram_addr};
            else if (ridx == cts_pkg::OFF_ENC_COUNT[10:2])
                rd_mux = enc_st;
            else if (ridx == cts_pkg::OFF_DEC_COUNT[10:2])
                rd_mux = dec_st;
            else if (key_hit(ridx, ek0))
                rd_mux = o_enc_key_value[ridx[1:0]*32 +: 32];
            else if (key_hit(ridx, dk0))
                rd_mux = o_dec_key_value[ridx[1:0]*32 +: 32];
        end
    end

    logic rd_req_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_req_q   <= 1'b0;
            o_rd_valid <= 1'b0;
            o_rd_data  <= 32'h0000_0000;
        end else if (i_ce) begin
            rd_req_q   <= i_rd_req;
            o_rd_valid <= rd_req_q;
            if (i_rd_req)
                o_rd_data <= rd_mux;
        end
    end

    // Checks
    a_enc_key_len: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && !enc_key_busy_flag && enc_busy_len != 4'h0 |->
        enc_busy_len == 4'(KC))
        else $error("encrypt key setting length wrong");
    a_dec_key_len: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && !dec_key_busy_flag && dec_busy_len != 4'h0 |->
        dec_busy_len == 4'(KC))
        else $error("decrypt key setting length wrong");
    a_rd_two_cyc: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_rd_req ##1 i_ce |=> o_rd_valid)
        else $error("read valid late");
    a_enc_zero_stop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_enc_block_in_done && enc_blocks_left == 7'h00 &&
        !wr_ec |=> !o_enc_block_in_valid)
        else $error("encrypt fed past zero");
    a_dec_zero_stop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_dec_block_in_done && dec_blocks_left == 7'h00 &&
        !wr_dc |=> !o_dec_block_in_valid)
        else $error("decrypt fed past zero");
    a_cipher_store: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        enc_res |=> o_cipher_wr.en &&
        o_cipher_wr.addr == $past(o_cipher_ram_addr))
        else $error("cipher store wrong");
    a_enc_start_go: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        enc_start |=> o_enc_block_in_valid &&
        enc_blocks_left == $past(wcnt) - 7'h1)
        else $error("encrypt start wrong");
    a_dec_start_go: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        dec_start |=> o_dec_block_in_valid)
        else $error("decrypt start missing");
    a_enc_key_strb: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr && i_wr.addr[10:2] == ek0 |=> o_enc_key_load_strobe)
        else $error("encrypt key strobe missing");
    a_dec_key_strb: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr && i_wr.addr[10:2] == dk0 |=> o_dec_key_load_strobe)
        else $error("decrypt key strobe missing");
    a_plain_store: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        dec_res |=> o_plain_wr.en &&
        o_plain_wr.addr == $past(o_plain_ram_addr))
        else $error("plain store wrong");
    a_enc_feed_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        enc_more && !enc_start |=> o_enc_block_in_valid &&
        enc_blocks_left == $past(enc_blocks_left) - 7'h1)
        else $error("encrypt feed step wrong");
    a_dec_feed_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        dec_more && !dec_start |=> o_dec_block_in_valid &&
        dec_blocks_left == $past(dec_blocks_left) - 7'h1)
        else $error("decrypt feed step wrong");
    // A result on the same RAM also steps it, so those cycles are left out
    a_plain_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        enc_feed && !dec_res && !wr_pa |=>
        o_plain_ram_addr == $past(o_plain_ram_addr) + 7'h1)
        else $error("plain address did not step");
    a_cipher_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        dec_feed && !enc_res && !wr_ca |=>
        o_cipher_ram_addr == $past(o_cipher_ram_addr) + 7'h1)
        else $error("cipher address did not step");
    a_enc_busy_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && enc_input_busy_flag && !i_enc_block_in_done |=>
        enc_input_busy_flag)
        else $error("encrypt input busy dropped early");
    a_dec_busy_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && dec_input_busy_flag && !i_dec_block_in_done |=>
        dec_input_busy_flag)
        else $error("decrypt input busy dropped early");
    a_area_ignore: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_wr.wr_en && !in_reg_area(i_wr.addr) |=>
        !o_enc_key_load_strobe && !o_dec_key_load_strobe)
        else $error("write outside register area took effect");
endmodule
`default_nettype wire

// ==== bench/cts_core_model.sv ====
// Behavioural cipher core as seen by the sequencer
`timescale 1ns/100ps
`default_nettype none
module cts_core_model #(
    parameter int LAT  = 8,
    parameter int SALT = 0
) (
    input  wire logic    i_clk,
    input  wire logic    i_rst_n,
    input  wire logic    i_in_valid,
    output logic         o_done,
    output logic         o_res_valid,
    output logic [127:0] o_res_word
);
    int wait_cnt;
    int n_out;
    // One block in flight; done and result pulse together
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_cnt <= 0;
            n_out <= 0;
            o_done <= 1'b0;
            o_res_valid <= 1'b0;
            o_res_word <= '0;
        end else begin
            o_done <= (wait_cnt == 1);
            o_res_valid <= (wait_cnt == 1);
            if (i_in_valid) wait_cnt <= LAT;
            else if (wait_cnt != 0) wait_cnt <= wait_cnt - 1;
            if (wait_cnt == 1) begin
                o_res_word <= {4{32'(n_out + SALT)}};
                n_out <= n_out + 1;
            end else begin
                o_res_word <= ~o_res_word; // No stale word outside valid
            end
        end
    end
endmodule
`default_nettype wire

// ==== bench/cts_top_test.sv ====
// Self-checking bench for the cipher test sequencer
`timescale 1ns/100ps
`default_nettype none
module cts_top_test;
    logic                 clk;
    logic                 rst_n;
    logic                 ce;
    cts_pkg::cts_wr_t     wr;
    logic                 rd_req;
    logic [15:0]          rd_addr;
    logic                 rd_valid;
    logic [31:0]          rd_data;
    logic [127:0]         key [2];
    wire [1:0]            kld;
    wire [1:0]            bin;
    wire [1:0]            done;
    wire [1:0]            rv;
    logic [127:0]         rw [2];
    logic [6:0]           pa;
    logic [6:0]           ca;
    cts_pkg::cts_ram_wr_t ram [2];
    logic [127:0]         rq [2][$];
    int                   num_errors = 0;
    int                   cmp_count = 0;
    int                   n_in [2];
    int                   n_wr [2];
    int                   n_kld [2];

    cts_top i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_wr(wr),
        .i_rd_req(rd_req), .i_rd_addr(rd_addr), .o_rd_valid(rd_valid),
        .o_rd_data(rd_data), .o_enc_key_value(key[0]),
        .o_enc_key_load_strobe(kld[0]), .o_dec_key_value(key[1]),
        .o_dec_key_load_strobe(kld[1]), .o_enc_block_in_valid(bin[0]),
        .i_enc_block_in_done(done[0]), .i_enc_result_valid(rv[0]),
        .i_enc_result_word(rw[0]), .o_dec_block_in_valid(bin[1]),
        .i_dec_block_in_done(done[1]), .i_dec_result_valid(rv[1]),
        .i_dec_result_word(rw[1]), .o_plain_ram_addr(pa),
        .o_cipher_ram_addr(ca), .o_plain_wr(ram[1]), .o_cipher_wr(ram[0]));

    for (genvar g = 0; g < 2; g++) begin : g_core
        cts_core_model #(.LAT(8 + g), .SALT(g * 256)) i_core (
            .i_clk(clk), .i_rst_n(rst_n), .i_in_valid(bin[g]),
            .o_done(done[g]), .o_res_valid(rv[g]), .o_res_word(rw[g]));
    end

    task automatic chk(string nm, logic [127:0] seen, logic [127:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Count feeds and strobes, check every buffer write
    always @(posedge clk) begin
        for (int s = 0; s < 2; s++) begin
            if (bin[s]) n_in[s]++;
            if (kld[s]) n_kld[s]++;
            if (rv[s]) rq[s].push_back(rw[s]);
            if (ram[s].en) begin
                chk("ram_addr", 128'(ram[s].addr), 128'(n_wr[s]));
                chk("ram_data", ram[s].data, rq[s].pop_front());
                n_wr[s]++;
            end
        end
    end

    task automatic wr_reg(logic [15:0] a, logic [31:0] d);
        @(negedge clk);
        wr = '{wr_en: 1'b1, addr: a, data: d};
        @(negedge clk);
        wr.wr_en = 1'b0;
    endtask

    task automatic rd_reg(logic [15:0] a, logic [31:0] e);
        @(negedge clk);
        rd_req = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_req = 1'b0;
        // Valid stands only in the cycle after the second edge
        @(negedge clk);
        chk("rd_valid", 128'(rd_valid), 128'h1);
        chk("rd_data", 128'(rd_data), 128'(e));
    endtask

    task automatic key_set(int s);
        logic [127:0] k;
        logic [15:0]  b;
        logic [15:0]  c;
        k = {$urandom, $urandom, $urandom, $urandom};
        b = s ? cts_pkg::OFF_DEC_KEY0 : cts_pkg::OFF_ENC_KEY0;
        c = cts_pkg::OFF_ENC_COUNT + 16'(4 * s);
        n_kld[s] = 0;
        for (int i = 3; i >= 0; i--) wr_reg(b + 16'(4 * i), k[32*i +: 32]);
        chk("key_value", key[s], k);
        repeat (6) @(negedge clk);
        rd_reg(c, 32'h100);
        rd_reg(c, 32'h0);
        chk("key_strobe", 128'(n_kld[s]), 128'h1);
    endtask

    task automatic run(int s, int n);
        logic [15:0] c;
        c = cts_pkg::OFF_ENC_COUNT + 16'(4 * s);
        wr_reg(cts_pkg::OFF_PLAIN_ADDR, 32'h0);
        wr_reg(cts_pkg::OFF_CIPHER_ADDR, 32'h0);
        n_in[s] = 0;
        n_wr[s] = 0;
        wr_reg(c, 32'hFFFF_FF80 | 32'(n));
        rd_reg(c, 32'h80 | 32'(n - 1));
        for (int i = 0; i < 400 && n_wr[s] < n; i++) @(posedge clk);
        repeat (30) @(posedge clk);
        chk("blocks_fed", 128'(n_in[s]), 128'(n));
        chk("src_addr", 128'(s ? ca : pa), 128'(n));
        chk("dst_addr", 128'(s ? pa : ca), 128'(n));
        chk("ram_writes", 128'(n_wr[s]), 128'(n));
        rd_reg(c, 32'h0);
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Cuts a hang well past the expected run length
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        wr = '0;
        rd_req = 1'b0;
        rd_addr = '0;
        void'($urandom(32'h26F1));
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        for (int s = 0; s < 2; s++) key_set(s);
        for (int s = 0; s < 2; s++) run(s, 1 + int'($urandom % 5));
        run(0, 1);
        n_in[0] = 0;
        wr_reg(16'h0808, 32'h3);
        // A write while the clock enable is low must be dropped
        ce = 1'b0;
        wr_reg(cts_pkg::OFF_ENC_COUNT, 32'h2);
        ce = 1'b1;
        wr_reg(cts_pkg::OFF_ENC_COUNT, 32'h0);
        repeat (20) @(posedge clk);
        chk("idle_feed", 128'(n_in[0]), 128'h0);
        rd_reg(16'h0010, 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
